// >>> hdl/rx_aligner_defs.svh
// register offsets, field positions, reset values and protocol counts
// assumes a 32-bit APB slave decoding byte addresses on paddr[7:0]
`ifndef RX_ALIGNER_DEFS_SVH
`define RX_ALIGNER_DEFS_SVH

// register offsets
`define RWA_OFF_CTRL      8'h00
`define RWA_OFF_PATTERN   8'h04
`define RWA_OFF_ACQ       8'h08
`define RWA_OFF_LOSS      8'h0C
`define RWA_OFF_GOOD      8'h10
`define RWA_OFF_STATUS    8'h14

// control field positions
`define RWA_CTRL_PROTO_LSB  0
`define RWA_CTRL_AMODE_LSB  3
`define RWA_CTRL_LEN10_BIT  5
`define RWA_CTRL_WIDTH8_BIT 6

// reset values
`define RWA_RST_PROTO     3'h0
`define RWA_RST_AMODE     2'h0
`define RWA_RST_LEN10     1'h1
`define RWA_RST_PATTERN   16'h017C
`define RWA_RST_ACQ       9'h004
`define RWA_RST_LOSS      7'h04
`define RWA_RST_GOOD      9'h004

// protocol comma, running disparity minus, serial order lsb first
`define RWA_COMMA         10'h17C

// fixed synchronization counts per protocol
`define RWA_PCIE_ACQ      9'h004
`define RWA_PCIE_LOSS     7'h11
`define RWA_PCIE_GOOD     9'h010
`define RWA_XAUI_ACQ      9'h004
`define RWA_XAUI_LOSS     7'h04
`define RWA_XAUI_GOOD     9'h004
`define RWA_GBE_ACQ       9'h003
`define RWA_GBE_LOSS      7'h04
`define RWA_GBE_GOOD      9'h004
`define RWA_SRIO_ACQ      9'h07F
`define RWA_SRIO_LOSS     7'h03
`define RWA_SRIO_GOOD     9'h0FF

`endif

// >>> hdl/rx_aligner_pkg.sv
// types shared by the word aligner and its bench
// assumes rx_aligner_defs.svh supplies all numbers
package rx_aligner_pkg;

  // functional mode of the channel
  typedef enum logic [2:0] {
    generic_mode              = 3'b000,
    pcie                      = 3'b001,
    xaui                      = 3'b010,
    gigabit_ethernet_mode     = 3'b011,
    serial_rapidio            = 3'b100,
    serial_digital_video_mode = 3'b101
  } proto_e;

  // aligner option in generic mode
  typedef enum logic [1:0] {
    align_manual  = 2'b00,
    align_auto    = 2'b01,
    align_bitslip = 2'b10
  } align_e;

  // synchronization state machine
  typedef enum logic [1:0] {
    sync_loss = 2'b00,
    sync_acq  = 2'b01,
    sync_ok   = 2'b10
  } sync_e;

  // word and status delivered to the fabric together
  typedef struct packed {
    logic [9:0] data;
    logic       sync;
    logic       hit;
  } rx_out_s;

endpackage : rx_aligner_pkg

// >>> hdl/rx_word_aligner_10bit.sv
// receive word aligner for a 10-bit single-width channel
// assumes rx_data_in and the fabric controls are on pclk, the
// parallel recovered clock; configuration arrives over APB
//
// How it works
// - each slip_request rising edge moves the boundary by one bit
// - 8-bit slip: earlier word is low byte, later word high byte
// - generic slip mode pattern_hit pulses one cycle on a pattern match
// - 10-bit slip mode takes 7-bit or 10-bit patterns
// - protocol modes other than video run the sync machine with a fixed comma
// - generic mode may pick the sync machine with own pattern
// - acquire count is 4, 4, 3, 127 or programmed 1 to 256
// - loss count is 17, 4, 4, 3 or programmed 1 to 64
// - good run to drop one error: 16, 4, 4, 255 or 1 to 256
// - after pcs_reset, search and raise sync at acquire count
// - sync holds until loss count of errors, then waits again
// - manual mode follows align_enable level and realigns
// - align_enable low keeps the current boundary
// - status leaves with the same latency as the data
// - first pattern after enable pulses sync and hit
// - later patterns on same boundary pulse only hit
// - every realignment while enabled pulses sync
// - patterns straddling two words are found at any offset
// - generic mode may pick manual alignment
// - generic may pick bit-slip; video mode always slips
//
// The APB register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "rx_aligner_defs.svh"

module rx_word_aligner_10bit (
  // clock, reset, enable
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    ce,
  // apb slave
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [7:0]              paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  // deserializer side
  input  wire logic                    pcs_reset,
  input  wire logic [9:0]              rx_data_in,
  // fabric controls
  input  wire logic                    align_enable,
  input  wire logic                    slip_request,
  // aligned word with status
  output rx_aligner_pkg::rx_out_s      rx_out
);

  // pattern compare, 7-bit form looks at the low seven bits
  function automatic logic pat_match(input logic [9:0] word,
                                     input logic [9:0] pat,
                                     input logic       len10);
    pat_match = len10 ? (word == pat) : (word[6:0] == pat[6:0]);
  endfunction : pat_match

  // lowest offset that holds a pattern, earliest in time
  function automatic logic [3:0] first_set(input logic [9:0] v);
    first_set = 4'h0;
    for (int i = 9; i >= 0; i--) begin
      if (v[i]) begin
        first_set = 4'(i);
      end
    end
  endfunction : first_set

  // cheap code check: a valid 8b/10b group holds four to six ones
  function automatic logic code_ok(input logic [9:0] word);
    logic [3:0] ones;
    ones = 4'h0;
    for (int i = 0; i < 10; i++) begin
      ones = ones + {3'h0, word[i]};
    end
    code_ok = (ones >= 4'h4) && (ones <= 4'h6);
  endfunction : code_ok

  // configuration registers
  rx_aligner_pkg::proto_e  proto;
  rx_aligner_pkg::align_e  amode;
  logic                    len10;
  logic                    width8;
  logic [15:0]             pattern;
  logic [8:0]              acq_thr_reg;
  logic [6:0]              loss_thr_reg;
  logic [8:0]              good_thr_reg;

  // datapath and machine state
  logic [9:0]              prev_in;
  logic [3:0]              pos;
  logic                    slip_q;
  logic                    arm;
  rx_aligner_pkg::sync_e   state;
  logic [8:0]              acq_cnt;
  logic [6:0]              err_cnt;
  logic [8:0]              good_cnt;

  // mode decode
  wire logic is_generic = (proto == rx_aligner_pkg::generic_mode);
  wire logic is_video =
    (proto == rx_aligner_pkg::serial_digital_video_mode);
  wire logic is_slip = is_video ||
    (is_generic && amode == rx_aligner_pkg::align_bitslip);
  wire logic is_auto = (!is_generic && !is_video) ||
    (is_generic && amode == rx_aligner_pkg::align_auto);
  wire logic is_manual = !is_slip && !is_auto;
  wire logic slip8 = is_slip && is_generic && width8;

  // pattern in use: protocols take the comma of either disparity
  wire logic [9:0] eff_pat =
    is_generic ? pattern[9:0] : `RWA_COMMA;
  wire logic eff_len10 = is_generic ? len10 :
    (proto == rx_aligner_pkg::pcie ||
     proto == rx_aligner_pkg::serial_rapidio);
  wire logic dual = !is_generic;

  // thresholds: fixed per protocol, programmed in generic mode
  logic [8:0] acq_thr;
  logic [6:0] loss_thr;
  logic [8:0] good_thr;
  always_comb begin
    case (proto)
      rx_aligner_pkg::pcie: begin
        acq_thr  = `RWA_PCIE_ACQ;
        loss_thr = `RWA_PCIE_LOSS;
        good_thr = `RWA_PCIE_GOOD;
      end
      rx_aligner_pkg::xaui: begin
        acq_thr  = `RWA_XAUI_ACQ;
        loss_thr = `RWA_XAUI_LOSS;
        good_thr = `RWA_XAUI_GOOD;
      end
      rx_aligner_pkg::gigabit_ethernet_mode: begin
        acq_thr  = `RWA_GBE_ACQ;
        loss_thr = `RWA_GBE_LOSS;
        good_thr = `RWA_GBE_GOOD;
      end
      rx_aligner_pkg::serial_rapidio: begin
        acq_thr  = `RWA_SRIO_ACQ;
        loss_thr = `RWA_SRIO_LOSS;
        good_thr = `RWA_SRIO_GOOD;
      end
      default: begin
        acq_thr  = acq_thr_reg;
        loss_thr = loss_thr_reg;
        good_thr = good_thr_reg;
      end
    endcase
  end

  // two-word window, earlier bits at the low end
  wire logic [19:0] win = {rx_data_in, prev_in};
  wire logic [19:0] win8 = {4'h0, rx_data_in[7:0], prev_in[7:0]};

  // pattern search at every offset, also across words
  logic [9:0] hit_at;
  genvar k;
  generate
    for (k = 0; k < 10; k++) begin : g_search
      assign hit_at[k] =
        pat_match(win[k +: 10], eff_pat, eff_len10) ||
        (dual && pat_match(~win[k +: 10], eff_pat, eff_len10));
    end
  endgenerate
  wire logic       any_hit = |hit_at;
  wire logic [3:0] new_pos = first_set(hit_at);

  // manual realign only while enabled; arm marks first pattern
  wire logic man_realign = is_manual && align_enable &&
    any_hit && (arm || new_pos != pos);
  wire logic auto_lock = is_auto && any_hit &&
    (state == rx_aligner_pkg::sync_loss);

  // slip edge seen on pclk; one shift per edge
  wire logic slip_rise = slip_request && !slip_q;
  wire logic [3:0] last_pos = slip8 ? 4'h7 : 4'h9;

  // boundary update
  logic [3:0] next_pos;
  always_comb begin
    if (is_slip) begin
      if (slip_rise) begin
        next_pos = (pos >= last_pos) ? 4'h0 : pos + 4'h1;
      end else begin
        next_pos = pos;
      end
    end else if (man_realign || auto_lock) begin
      next_pos = new_pos;
    end else begin
      next_pos = pos;
    end
  end

  // word at the boundary in force for this cycle
  wire logic [3:0] sel =
    (man_realign || auto_lock) ? new_pos : pos;
  wire logic [9:0] sw = slip8 ? {2'h0, win8[sel +: 8]} : win[sel +: 10];
  wire logic sw_hit = pat_match(sw, eff_pat, eff_len10) ||
    (dual && pat_match(~sw, eff_pat, eff_len10));
  // earlier word is the low byte, the newer one the high byte
  wire logic slip_hit16 =
    ({sw[7:0], rx_out.data[7:0]} == pattern);

  // a group is bad if its code is wrong or a comma is misplaced
  wire logic bad = !code_ok(sw) || (any_hit && !hit_at[sel]);

  // sums widened for compare against thresholds
  wire logic [9:0] acq_inc  = {1'b0, acq_cnt} + 10'h001;
  wire logic [7:0] err_inc  = {1'b0, err_cnt} + 8'h01;
  wire logic [9:0] good_inc = {1'b0, good_cnt} + 10'h001;

  // synchronization state machine
  rx_aligner_pkg::sync_e next_state;
  logic [8:0] next_acq;
  logic [6:0] next_err;
  logic [8:0] next_good;
  always_comb begin
    next_state = state;
    next_acq   = acq_cnt;
    next_err   = err_cnt;
    next_good  = good_cnt;
    case (state)
      rx_aligner_pkg::sync_loss: begin
        if (auto_lock) begin
          next_acq   = 9'h001;
          next_state = (acq_thr <= 9'h001) ?
            rx_aligner_pkg::sync_ok : rx_aligner_pkg::sync_acq;
        end
      end
      rx_aligner_pkg::sync_acq: begin
        if (bad) begin
          next_state = rx_aligner_pkg::sync_loss;
          next_acq   = 9'h000;
        end else if (sw_hit) begin
          next_acq = acq_inc[8:0];
          if (acq_inc >= {1'b0, acq_thr}) begin
            next_state = rx_aligner_pkg::sync_ok;
            next_err   = 7'h00;
            next_good  = 9'h000;
          end
        end
      end
      rx_aligner_pkg::sync_ok: begin
        if (bad) begin
          next_good = 9'h000;
          next_err  = err_inc[6:0];
          if (err_inc >= {1'b0, loss_thr}) begin
            next_state = rx_aligner_pkg::sync_loss;
            next_err   = 7'h00;
            next_acq   = 9'h000;
          end
        end else if (good_inc >= {1'b0, good_thr}) begin
          next_good = 9'h000;
          if (err_cnt != 7'h00) begin
            next_err = err_cnt - 7'h01;
          end
        end else begin
          next_good = good_inc[8:0];
        end
      end
      default: begin
        next_state = rx_aligner_pkg::sync_loss;
      end
    endcase
    if (!is_auto) begin
      next_state = rx_aligner_pkg::sync_loss;
    end
  end

  // status formed on the same word it belongs to
  logic next_sync;
  logic next_hit;
  always_comb begin
    if (is_slip) begin
      next_sync = 1'b0;
      if (is_video) begin
        next_hit = 1'b0;
      end else if (slip8) begin
        next_hit = slip_hit16;
      end else begin
        next_hit = sw_hit;
      end
    end else if (is_auto) begin
      next_sync = (next_state == rx_aligner_pkg::sync_ok);
      next_hit  = sw_hit;
    end else begin
      next_sync = man_realign;
      next_hit  = sw_hit;
    end
  end

  // aligned word and status leave in one register stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_out <= '0;
    end else if (ce) begin
      if (pcs_reset) begin
        rx_out <= '0;
      end else begin
        rx_out.data <= sw;
        rx_out.sync <= next_sync;
        rx_out.hit  <= next_hit;
      end
    end
  end

  // boundary, edge history and arm flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_in <= 10'h000;
      pos     <= 4'h0;
      slip_q  <= 1'b0;
      arm     <= 1'b1;
    end else if (ce) begin
      prev_in <= rx_data_in;
      slip_q  <= slip_request;
      if (pcs_reset) begin
        pos <= 4'h0;
        arm <= 1'b1;
      end else begin
        pos <= next_pos;
        // low enable re-arms so the next first pattern reports
        arm <= !align_enable || (arm && !man_realign);
      end
    end
  end

  // machine state and counters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state    <= rx_aligner_pkg::sync_loss;
      acq_cnt  <= 9'h000;
      err_cnt  <= 7'h00;
      good_cnt <= 9'h000;
    end else if (ce) begin
      if (pcs_reset) begin
        state    <= rx_aligner_pkg::sync_loss;
        acq_cnt  <= 9'h000;
        err_cnt  <= 7'h00;
        good_cnt <= 9'h000;
      end else begin
        state    <= next_state;
        acq_cnt  <= next_acq;
        err_cnt  <= next_err;
        good_cnt <= next_good;
      end
    end
  end

  // apb decode; one wait state keeps prdata from a flop
  wire logic acc      = psel && penable;
  wire logic next_rdy = acc && !pready;
  wire logic wr_fire  = acc && pready && pwrite;
  wire logic hit_ctrl = (paddr == `RWA_OFF_CTRL);
  wire logic hit_pat  = (paddr == `RWA_OFF_PATTERN);
  wire logic hit_acq  = (paddr == `RWA_OFF_ACQ);
  wire logic hit_loss = (paddr == `RWA_OFF_LOSS);
  wire logic hit_good = (paddr == `RWA_OFF_GOOD);
  wire logic hit_stat = (paddr == `RWA_OFF_STATUS);
  wire logic mapped   = hit_ctrl || hit_pat || hit_acq ||
    hit_loss || hit_good || hit_stat;

  // read mux; unused bits read as zero
  logic [31:0] rd_val;
  always_comb begin
    rd_val = 32'h00000000;
    if (hit_ctrl) begin
      rd_val[`RWA_CTRL_PROTO_LSB +: 3] = proto;
      rd_val[`RWA_CTRL_AMODE_LSB +: 2] = amode;
      rd_val[`RWA_CTRL_LEN10_BIT]      = len10;
      rd_val[`RWA_CTRL_WIDTH8_BIT]     = width8;
    end
    if (hit_pat) begin
      rd_val[15:0] = pattern;
    end
    if (hit_acq) begin
      rd_val[8:0] = acq_thr_reg;
    end
    if (hit_loss) begin
      rd_val[6:0] = loss_thr_reg;
    end
    if (hit_good) begin
      rd_val[8:0] = good_thr_reg;
    end
    if (hit_stat) begin
      rd_val[6:0] = {rx_out.sync, state, pos};
    end
  end

  // apb answer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else if (ce) begin
      pready  <= next_rdy;
      pslverr <= next_rdy && !mapped;
      if (next_rdy) begin
        prdata <= pwrite ? 32'h00000000 : rd_val;
      end
    end
  end

  // configuration writes land on the completing edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      proto        <= rx_aligner_pkg::proto_e'(`RWA_RST_PROTO);
      amode        <= rx_aligner_pkg::align_e'(`RWA_RST_AMODE);
      len10        <= `RWA_RST_LEN10;
      width8       <= 1'b0;
      pattern      <= `RWA_RST_PATTERN;
      acq_thr_reg  <= `RWA_RST_ACQ;
      loss_thr_reg <= `RWA_RST_LOSS;
      good_thr_reg <= `RWA_RST_GOOD;
    end else if (ce && wr_fire) begin
      if (hit_ctrl) begin
        proto  <= rx_aligner_pkg::proto_e'(
                    pwdata[`RWA_CTRL_PROTO_LSB +: 3]);
        amode  <= rx_aligner_pkg::align_e'(
                    pwdata[`RWA_CTRL_AMODE_LSB +: 2]);
        len10  <= pwdata[`RWA_CTRL_LEN10_BIT];
        width8 <= pwdata[`RWA_CTRL_WIDTH8_BIT];
      end
      if (hit_pat) begin
        pattern <= pwdata[15:0];
      end
      if (hit_acq) begin
        acq_thr_reg <= pwdata[8:0];
      end
      if (hit_loss) begin
        loss_thr_reg <= pwdata[6:0];
      end
      if (hit_good) begin
        good_thr_reg <= pwdata[8:0];
      end
    end
  end

endmodule : rx_word_aligner_10bit

// >>> bench/rx_aligner_sva.sv
// concurrent checks on the word aligner ports
// assumes one pclk domain; config is shadowed from completed apb writes
`timescale 1ns/1ps
`include "rx_aligner_defs.svh"

module rx_aligner_sva (
  // clock, reset, enable
  input logic                    pclk,
  input logic                    presetn,
  input logic                    ce,
  // apb slave
  input logic                    psel,
  input logic                    penable,
  input logic                    pwrite,
  input logic [7:0]              paddr,
  input logic [31:0]             pwdata,
  input logic [31:0]             prdata,
  input logic                    pready,
  input logic                    pslverr,
  // datapath and fabric controls
  input logic                    pcs_reset,
  input logic [9:0]              rx_data_in,
  input logic                    align_enable,
  input logic                    slip_request,
  input rx_aligner_pkg::rx_out_s rx_out
);
  logic [6:0] ctrl_q, ctrl_d;
  logic [9:0] pat_q;
  wire        wr_done = psel && penable && pready && pwrite && ce;
  // mode words only count once stable for a cycle, so words still in
  // flight from the old mode are not judged by the new one
  wire        cfg_still = ctrl_q == ctrl_d;
  wire        man = ctrl_q[2:0] == 3'h0 && ctrl_q[4] == ctrl_q[3] && cfg_still;
  wire        slp = (ctrl_q[2:0] == 3'h5 ||
                    (ctrl_q[2:0] == 3'h0 && ctrl_q[4:3] == 2'h2)) && cfg_still;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // shadow of control and pattern registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= 7'h20;
      ctrl_d <= 7'h20;
      pat_q  <= 10'h17C;
    end else begin
      ctrl_d <= ctrl_q;
      if (wr_done && paddr == `RWA_OFF_CTRL) ctrl_q <= pwdata[6:0];
      if (wr_done && paddr == `RWA_OFF_PATTERN) pat_q <= pwdata[9:0];
    end
  end

  ready_once_a: assert property (pready && ce |=> !pready)
    else $error("pready held longer than one cycle");
  one_wait_a: assert property (psel && penable && !pready && ce |=> pready)
    else $error("apb answer not one cycle after access");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  clr_out_a: assert property (pcs_reset |=> rx_out == '0)
    else $error("rx_out not cleared under pcs_reset");
  sync_hit_a: assert property (man && rx_out.sync |-> rx_out.hit)
    else $error("manual sync pulse without hit");
  sync_pulse_a: assert property (man && rx_out.sync |=> !rx_out.sync)
    else $error("manual sync longer than one cycle");
  enable_gate_a: assert property (man && rx_out.sync |->
    $past(align_enable)) else $error("realigned while align_enable low");
  hit_pattern_a: assert property (man && ctrl_q[5] && rx_out.hit |->
    rx_out.data == pat_q) else $error("manual hit on a non-pattern word");
  slip_nosync_a: assert property (slp |-> !rx_out.sync)
    else $error("sync raised in slip mode");
  byte_upper_a: assert property (slp && ctrl_q[6] && !ctrl_q[2] |->
    rx_out.data[9:8] == 2'h0) else $error("upper bits set in byte slip");
endmodule : rx_aligner_sva

bind rx_word_aligner_10bit rx_aligner_sva rx_aligner_sva_i (
  .pclk(pclk),
  .presetn(presetn),
  .ce(ce),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .pcs_reset(pcs_reset),
  .rx_data_in(rx_data_in),
  .align_enable(align_enable),
  .slip_request(slip_request),
  .rx_out(rx_out)
);

// >>> bench/fabric_model.sv
// fabric control logic: align enable with self-lock, slip pulses
// assumes status and controls all live on pclk
`timescale 1ns/1ps

module fabric_model (
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // bench commands
  input  wire logic              want_align,
  input  wire logic              slip_go,
  output logic                   slip_busy,
  // aligner side
  input  rx_aligner_pkg::rx_out_s rx_out,
  output logic                   align_enable,
  output logic                   slip_request
);
  logic       locked;
  logic [1:0] slip_cnt;
  // lock once a realignment is reported: a comma straddling two
  // words would otherwise pull the boundary away
  wire next_locked = want_align &&
                     (locked || (rx_out.sync === 1'h1 && align_enable));

  // slip request high two cycles, then at least one low
  assign slip_request = slip_cnt[1];
  assign slip_busy    = slip_cnt != 2'h0;

  // enable and slip sequencing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      locked       <= 1'h0;
      align_enable <= 1'h0;
      slip_cnt     <= 2'h0;
    end else begin
      locked       <= next_locked;
      align_enable <= want_align && !next_locked;
      if (slip_cnt != 2'h0) slip_cnt <= slip_cnt - 2'h1;
      else if (slip_go) slip_cnt <= 2'h3;
    end
  end
endmodule : fabric_model

// >>> bench/tb.sv
// bench top: registers, manual alignment, sync machine, bit slip
// assumes aligner, checker and fabric model are compiled before it
`timescale 1ns/1ps
`include "rx_aligner_defs.svh"
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
  n_mismatch++; $display("ERROR %s exp %0h got %0h", nm, e, g); end end

module tb;
  localparam logic [9:0]   fill_word = 10'h2AA;
  logic                    pclk, presetn, psel, penable, pwrite;
  logic                    pready, pslverr, err, pcs_reset;
  logic [7:0]              paddr;
  logic [31:0]             pwdata, prdata, rd;
  logic [9:0]              rx_data_in, hit_data;
  logic                    align_enable, slip_request;
  logic                    want_align, slip_go, slip_busy;
  rx_aligner_pkg::rx_out_s rx_out;
  int                      n_mismatch, checks_done, n_hit, n_sync;

  rx_word_aligner_10bit rx_word_aligner_10bit_i (
    .pclk(pclk), .presetn(presetn), .ce(1'h1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pcs_reset(pcs_reset), .rx_data_in(rx_data_in),
    .align_enable(align_enable), .slip_request(slip_request),
    .rx_out(rx_out));

  fabric_model fabric_model_i (
    .pclk(pclk), .presetn(presetn), .want_align(want_align),
    .slip_go(slip_go), .slip_busy(slip_busy), .rx_out(rx_out),
    .align_enable(align_enable), .slip_request(slip_request));

  initial begin
    pclk = 1'h0;
    forever #10 pclk = ~pclk;
  end

  // status pulses counted once each, at the edge after they appear
  always @(posedge pclk) begin
    if (rx_out.hit === 1'h1) begin
      n_hit++;
      hit_data = rx_out.data;
    end
    if (rx_out.sync === 1'h1) n_sync++;
  end

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict

  task automatic give_up(input string what);
    $display("ERROR %s timeout exp 1 got 0", what);
    n_mismatch++;
    print_verdict;
  endtask : give_up

  // one apb transfer; waits for pready, never assumes its latency
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel    <= 1'h1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    penable <= 1'h0;
    @(posedge pclk);
    penable <= 1'h1;
    for (i = 0; i < 20 && pready !== 1'h1; i++) @(posedge pclk);
    if (i >= 20) give_up("pready");
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  task automatic word(input logic [9:0] w);
    @(posedge pclk);
    rx_data_in <= w;
  endtask : word

  // mode and pattern change only while the aligner is held clear
  task automatic cfg(input logic [31:0] ctl, input logic [31:0] pat);
    @(posedge pclk);
    pcs_reset <= 1'h1;
    apb(1'h1, `RWA_OFF_CTRL, ctl);
    apb(1'h1, `RWA_OFF_PATTERN, pat);
    `CHK("out_in_reset", 12'h000, rx_out)
    @(posedge pclk);
    pcs_reset <= 1'h0;
    @(negedge pclk);
    n_hit  = 0;
    n_sync = 0;
  endtask : cfg

  // comma spliced at bit offset off, then idle filler
  task automatic comma_at(input int off);
    logic [29:0] blk;
    blk = {3{fill_word}};
    blk[off+:10] = `RWA_COMMA;
    word(blk[9:0]);
    word(blk[19:10]);
    word(blk[29:20]);
    repeat (4) word(fill_word);
    @(negedge pclk);
  endtask : comma_at

  // one slip request through the fabric model, then the settled word
  task automatic slip;
    int i;
    @(posedge pclk);
    slip_go <= 1'h1;
    @(posedge pclk);
    slip_go <= 1'h0;
    @(posedge pclk);
    for (i = 0; i < 10 && slip_busy !== 1'h0; i++) @(posedge pclk);
    if (i >= 10) give_up("slip_busy");
    repeat (2) @(posedge pclk);
    @(negedge pclk);
  endtask : slip

  task automatic t_regs;
    apb(1'h0, `RWA_OFF_CTRL, 32'h0);
    `CHK("ctrl_rst", 32'h0000_0020, rd)
    apb(1'h0, `RWA_OFF_PATTERN, 32'h0);
    `CHK("pattern_rst", 32'h0000_017C, rd)
    apb(1'h0, `RWA_OFF_LOSS, 32'h0);
    `CHK("loss_rst", 32'h0000_0004, rd)
    apb(1'h0, 8'h3C, 32'h0);
    `CHK("unmapped_err", 1'h1, err)
    apb(1'h1, `RWA_OFF_ACQ, 32'h0000_0002);
    apb(1'h1, `RWA_OFF_LOSS, 32'h0000_0002);
    apb(1'h0, `RWA_OFF_ACQ, 32'h0);
    `CHK("acq_rw", 32'h0000_0002, rd)
  endtask : t_regs

  task automatic t_manual;
    cfg(32'h0000_0020, 32'h0000_017C);
    @(posedge pclk);
    want_align <= 1'h1;
    comma_at(3);
    `CHK("first_sync", 1, n_sync)
    `CHK("first_hit", 1, n_hit)
    `CHK("hit_word", `RWA_COMMA, hit_data)
    comma_at(3);
    `CHK("same_sync", 1, n_sync)
    `CHK("same_hit", 2, n_hit)
    comma_at(7);
    `CHK("locked_hit", 2, n_hit)
    `CHK("locked_sync", 1, n_sync)
    @(posedge pclk);
    want_align <= 1'h0;
    repeat (2) word(fill_word);
    want_align <= 1'h1;
    comma_at(7);
    `CHK("realign_sync", 2, n_sync)
    `CHK("realign_hit", 3, n_hit)
    `CHK("realign_word", `RWA_COMMA, hit_data)
    @(posedge pclk) want_align <= 1'h0;
  endtask : t_manual

  task automatic t_auto;
    cfg(32'h0000_0028, 32'h0000_017C);
    comma_at(0);
    `CHK("sync_early", 1'h0, rx_out.sync)
    repeat (2) word(`RWA_COMMA);
    repeat (4) word(fill_word);
    @(negedge pclk);
    `CHK("sync_acquired", 1'h1, rx_out.sync)
    word(10'h000);
    repeat (6) word(fill_word);
    @(negedge pclk);
    `CHK("sync_one_error", 1'h1, rx_out.sync)
    repeat (2) word(10'h000);
    repeat (4) word(fill_word);
    @(negedge pclk);
    `CHK("sync_lost", 1'h0, rx_out.sync)
    cfg(32'h3, 32'h0);
    repeat (2) comma_at(0);
    `CHK("gbe_early", 1'h0, rx_out.sync)
    comma_at(0);
    `CHK("gbe_sync", 1'h1, rx_out.sync)
  endtask : t_auto

  task automatic t_slip10;
    logic [9:0] w;
    cfg(32'h0000_0030, 32'h0000_017C);
    w = 10'h3E0;
    repeat (4) word(w);
    @(negedge pclk);
    `CHK("slip_start", w, rx_out.data)
    repeat (3) begin
      slip;
      w = {w[0], w[9:1]};
      `CHK("slip10_word", w, rx_out.data)
    end
  endtask : t_slip10

  task automatic t_slip8;
    logic [7:0] b;
    cfg(32'h0000_0050, 32'h0000_0F1E);
    b = 8'hF0;
    repeat (4) word({2'h0, b});
    @(negedge pclk);
    repeat (4) begin
      slip;
      b = {b[0], b[7:1]};
      `CHK("slip8_word", {2'h0, b}, rx_out.data)
    end
    `CHK("slip8_hits", 1, n_hit)
  endtask : t_slip8

  initial begin
    presetn    = 1'h0;
    psel       = 1'h0;
    penable    = 1'h0;
    pwrite     = 1'h0;
    paddr      = 8'h00;
    pwdata     = 32'h0;
    pcs_reset  = 1'h1;
    rx_data_in = fill_word;
    want_align = 1'h0;
    slip_go    = 1'h0;
    repeat (2) @(posedge pclk);
    `CHK("out_in_presetn", 12'h000, rx_out)
    presetn <= 1'h1;
    t_regs;
    t_manual;
    t_auto;
    t_slip10;
    t_slip8;
    print_verdict;
  end
endmodule : tb
